// *** port6_consts.svh ***
`ifndef PORT6_CONSTS_SVH
`define PORT6_CONSTS_SVH

// Byte offsets of the word-aligned registers on the bus
`define DIR_OFFSET      4'h0
`define LATCH_OFFSET    4'h4
`define PULLUP_OFFSET   4'h8

// Reset and fixed read values
`define PORT_RESET      8'h00
`define DIR_READ_VALUE  8'hFF
`define IDLE_FEED       1'b1
`define BUS_ZERO        32'h0000_0000

// Pin positions of the multiplexed functions
`define PIN_CAPTURE_C   4
`define PIN_CAPTURE_D   5
`define PIN_COMPARE_B   6
`define PIN_INT_SEVEN   7
`define KEY_LOW_PIN     4

`endif

// *** port6_pkg.sv ***
package port6_pkg;

  typedef enum logic [1:0] {
    SEL_DIR,
    SEL_LATCH,
    SEL_PULLUP,
    SEL_NONE
  } reg_sel_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage

// *** pin_sync.sv ***
`include "port6_consts.svh"

module pin_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] raw,
  output logic      [7:0] level
);

  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;
  logic [7:0] next_level;

  // Level moves only once the last two stages agree; stage1 feeds stage2 alone
  always_comb begin
    next_level = level;
    for (int i = 0; i < 8; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= `PORT_RESET;
      stage2 <= `PORT_RESET;
      stage3 <= `PORT_RESET;
      level  <= `PORT_RESET;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule // pin_sync

// *** pin_func_select.sv ***
`include "port6_consts.svh"

module pin_func_select (
  input  wire logic [7:0] dir_bits,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] pullup_sel,
  input  wire logic [7:0] pin_level,
  input  wire logic       compare_out_b_enable,
  input  wire logic       timer_compare_out_b,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pullup_on,
  output logic      [7:0] port_read
);

  // No mode input exists, so selection is identical in every mode
  always_comb begin
    pin_oe  = dir_bits;
    pin_out = latch;
    if (compare_out_b_enable) begin
      pin_oe[`PIN_COMPARE_B]  = 1'b1;
      pin_out[`PIN_COMPARE_B] = timer_compare_out_b;
    end
  end

  // Pull-up wherever the direction bit is clear and the select bit set, even on pin 6 while the timer drives it
  assign pullup_on = pullup_sel & ~dir_bits;

  // Pins with the direction bit set read the latch, the others read the pin
  assign port_read = (latch & dir_bits) | (pin_level & ~dir_bits);

endmodule // pin_func_select

// *** port6_block.sv ***
`include "port6_consts.svh"

module port6_block (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pullup_on,
  input  wire logic        compare_out_b_enable,
  input  wire logic        timer_compare_out_b,
  input  wire logic        ext_int_seven_enable,
  input  wire logic        ext_int_six_enable,
  output logic             timer_capture_in_c,
  output logic             timer_capture_in_d,
  output logic             ext_int_seven_n,
  output logic             ext_int_six_n,
  output logic      [3:0]  key_sense_input
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the read and the write path

  function automatic port6_pkg::reg_sel_t decode(input logic [3:0] addr);
    port6_pkg::reg_sel_t sel;
    case (addr)
      `DIR_OFFSET:    sel = port6_pkg::SEL_DIR;
      `LATCH_OFFSET:  sel = port6_pkg::SEL_LATCH;
      `PULLUP_OFFSET: sel = port6_pkg::SEL_PULLUP;
      default:        sel = port6_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs

  logic [7:0] pin_level;
  logic [7:0] standby_level;
  logic       hw_standby_sync;

  pin_sync u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   (pin_in),
    .level (pin_level)
  );

  // Standby arrives from a pin, so it takes the same filter
  pin_sync u_standby_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   ({7'h00, hw_standby}),
    .level (standby_level)
  );

  assign hw_standby_sync = standby_level[0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, the register read settles in it

  port6_pkg::bus_state_t state;
  port6_pkg::bus_state_t next_state;
  logic [31:0]           next_readdata;
  logic [7:0]            port_read;
  port6_pkg::reg_sel_t   sel;
  logic                  req;
  logic                  commit_write;

  assign req          = read | write;
  assign sel          = decode(address);
  assign waitrequest  = req & (state == port6_pkg::BUS_IDLE);
  assign commit_write = write & (state == port6_pkg::BUS_ACK) & byteenable[0];

  always_comb begin
    next_state    = state;
    next_readdata = readdata;
    case (state)
      port6_pkg::BUS_IDLE: begin
        if (req) begin
          next_state    = port6_pkg::BUS_ACK;
          next_readdata = `BUS_ZERO;
          if (read) begin
            case (sel)
              port6_pkg::SEL_DIR:    next_readdata[7:0] = `DIR_READ_VALUE;
              port6_pkg::SEL_LATCH:  next_readdata[7:0] = port_read;
              port6_pkg::SEL_PULLUP: next_readdata[7:0] = pullup_sel;
              default:               next_readdata = `BUS_ZERO;
            endcase
          end
        end
      end
      port6_pkg::BUS_ACK: begin
        next_state = port6_pkg::BUS_IDLE;
      end
      default: begin
        next_state = port6_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= port6_pkg::BUS_IDLE;
      readdata <= `BUS_ZERO;
    end else begin
      state    <= next_state;
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port registers

  logic [7:0] dir_bits;
  logic [7:0] latch;
  logic [7:0] pullup_sel;
  logic [7:0] next_dir_bits;
  logic [7:0] next_latch;
  logic [7:0] next_pullup_sel;

  // Software standby only stops the CPU, so nothing here reacts to it
  always_comb begin
    next_dir_bits   = dir_bits;
    next_latch      = latch;
    next_pullup_sel = pullup_sel;
    if (hw_standby_sync) begin
      next_dir_bits   = `PORT_RESET;
      next_latch      = `PORT_RESET;
      next_pullup_sel = `PORT_RESET;
    end else if (commit_write) begin
      case (sel)
        port6_pkg::SEL_DIR:    next_dir_bits   = writedata[7:0];
        port6_pkg::SEL_LATCH:  next_latch      = writedata[7:0];
        port6_pkg::SEL_PULLUP: next_pullup_sel = writedata[7:0];
        default:               next_latch      = latch;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_bits   <= `PORT_RESET;
      latch      <= `PORT_RESET;
      pullup_sel <= `PORT_RESET;
    end else begin
      dir_bits   <= next_dir_bits;
      latch      <= next_latch;
      pullup_sel <= next_pullup_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and pull-ups

  pin_func_select u_pin_func_select (
    .dir_bits             (dir_bits),
    .latch                (latch),
    .pullup_sel           (pullup_sel),
    .pin_level            (pin_level),
    .compare_out_b_enable (compare_out_b_enable),
    .timer_compare_out_b  (timer_compare_out_b),
    .pin_out              (pin_out),
    .pin_oe               (pin_oe),
    .pullup_on            (pullup_on),
    .port_read            (port_read)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Function feeds; an output pin feeds an idle high so that it cannot
  // raise a false capture edge or a low interrupt level

  logic [7:0] feed;
  logic [7:0] next_feed;

  always_comb begin
    next_feed = pin_level;
    for (int i = `KEY_LOW_PIN; i < 8; i++) begin
      if (pin_oe[i]) begin
        next_feed[i] = `IDLE_FEED;
      end
    end
    if (!ext_int_seven_enable) begin
      next_feed[`PIN_INT_SEVEN] = `IDLE_FEED;
    end
  end

  logic next_int_six_n;
  logic int_six_n;

  always_comb begin
    next_int_six_n = `IDLE_FEED;
    if (ext_int_six_enable && !pin_oe[`PIN_COMPARE_B]) begin
      next_int_six_n = pin_level[`PIN_COMPARE_B];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      feed      <= 8'hFF;
      int_six_n <= `IDLE_FEED;
    end else begin
      feed      <= next_feed;
      int_six_n <= next_int_six_n;
    end
  end

  // Key-sense sees the pin regardless of interrupt enables
  logic [7:0] key_feed;
  logic [7:0] next_key_feed;

  always_comb begin
    next_key_feed = pin_level | pin_oe;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_feed <= 8'hFF;
    end else begin
      key_feed <= next_key_feed;
    end
  end

  assign timer_capture_in_c = feed[`PIN_CAPTURE_C];
  assign timer_capture_in_d = feed[`PIN_CAPTURE_D];
  assign ext_int_seven_n    = feed[`PIN_INT_SEVEN];
  assign ext_int_six_n      = int_six_n;
  assign key_sense_input    = key_feed[7:4];

endmodule // port6_block

// *** port6_block_asserts.sv ***
module port6_block_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        hw_standby,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pullup_on,
  input wire logic        compare_out_b_enable,
  input wire logic        timer_compare_out_b,
  input wire logic        ext_int_seven_enable,
  input wire logic        ext_int_seven_n,
  input wire logic        ext_int_six_n,
  input wire logic        timer_capture_in_c,
  input wire logic [3:0]  key_sense_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ack; !waitrequest; endsequence
  // Exactly one wait cycle per transfer
  AST_ACK: assert property (s_req |=> s_ack)
    else $error("bus ack missing after one wait cycle");
  AST_RD_UPPER: assert property (s_ack ##0 read |-> readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  // Bit 6 skipped: its enable may come from the timer, not the direction bit
  AST_PULLUP_OUT: assert property ((pullup_on & pin_oe & 8'hBF) == 8'h00)
    else $error("pull-up on for an output pin");
  // Filter delay is about four cycles, so eight high samples is a safe margin
  AST_HW_CLEAR: assert property (hw_standby [*8] |-> pullup_on == 8'h00)
    else $error("pull-ups not cleared in hardware standby");
  AST_PIN6_FORCE: assert property (compare_out_b_enable |-> pin_oe[6] && pin_out[6] == timer_compare_out_b)
    else $error("pin 6 not driven by timer compare");
  AST_INT7_GATE: assert property (!$past(ext_int_seven_enable) |-> ext_int_seven_n)
    else $error("pin 7 interrupt feed not gated");
  AST_INT6_GATE: assert property ($past(pin_oe[6]) |-> ext_int_six_n)
    else $error("pin 6 interrupt feed active while driven");
  AST_KEY_OUT: assert property (($past(pin_oe[7:4]) & ~key_sense_input) == 4'h0)
    else $error("key feed active on output pin");
  AST_CAPT_OUT: assert property ($past(pin_oe[4]) |-> timer_capture_in_c)
    else $error("capture feed active on output pin");
endmodule // port6_block_asserts

bind port6_block port6_block_asserts u_asserts (.*);

// *** tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
  logic [3:0]  address = 4'h0, byteenable = 4'hF, key_sense_input;
  logic [31:0] writedata = 32'h0, readdata;
  logic [7:0]  pin_in = 8'h3C, pin_out, pin_oe, pullup_on;
  logic        hw_standby = 1'b0, sw_standby = 1'b0, timer_capture_in_c, timer_capture_in_d;
  logic        compare_out_b_enable = 1'b0, timer_compare_out_b = 1'b0;
  logic        ext_int_seven_enable = 1'b0, ext_int_six_enable = 1'b0;
  logic        ext_int_seven_n, ext_int_six_n;
  int          cycles = 0, miscompares = 0, comparisons = 0;

  port6_block u_dut (.*);

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low; an edge passes after release
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h000000, d};
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    do @(posedge clk); while (waitrequest);
    if (!wr) chk("readdata", readdata, {24'h000000, d});
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    xfer(0, 4'h8, 8'h00);
    xfer(0, 4'h0, 8'hFF);
    xfer(0, 4'h4, 8'h3C);
    xfer(0, 4'hC, 8'h00);
    xfer(1, 4'h8, 8'hFF);
    xfer(0, 4'h8, 8'hFF);
    chk("pullup_on", pullup_on, 8'hFF);
    xfer(1, 4'h0, 8'h0F);
    xfer(1, 4'h4, 8'h5A);
    chk("pullup_on", pullup_on, 8'hF0);
    chk("pin_oe", pin_oe, 8'h0F);
    chk("pin_out", pin_out, 8'h5A);
    xfer(0, 4'h4, 8'h3A);
    ext_int_seven_enable <= 1'b1;
    ext_int_six_enable <= 1'b1;
    repeat (2) @(posedge clk);
    chk("keys", key_sense_input, 4'h3);
    chk("capture", {timer_capture_in_d, timer_capture_in_c}, 2'b11);
    chk("ints", {ext_int_seven_n, ext_int_six_n}, 2'b00);
    ext_int_seven_enable <= 1'b0;
    ext_int_six_enable <= 1'b0;
    repeat (2) @(posedge clk);
    chk("ints", {ext_int_seven_n, ext_int_six_n}, 2'b11);
    xfer(1, 4'h0, 8'hF0);
    repeat (2) @(posedge clk);
    chk("keys", key_sense_input, 4'hF);
    chk("capture", {timer_capture_in_d, timer_capture_in_c}, 2'b11);
    xfer(1, 4'h0, 8'h00);
    compare_out_b_enable <= 1'b1;
    timer_compare_out_b <= 1'b1;
    @(posedge clk);
    chk("pin6", {pin_oe[6], pin_out[6]}, 2'b11);
    timer_compare_out_b <= 1'b0;
    @(posedge clk);
    chk("pin6", {pin_oe[6], pin_out[6]}, 2'b10);
    compare_out_b_enable <= 1'b0;
    @(posedge clk);
    chk("pin6_oe", pin_oe[6], 1'b0);
    // Write with the low byte lane off must not land
    byteenable <= 4'hE;
    xfer(1, 4'h8, 8'h00);
    byteenable <= 4'hF;
    sw_standby <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(0, 4'h8, 8'hFF);
    hw_standby <= 1'b1;
    repeat (10) @(posedge clk);
    hw_standby <= 1'b0;
    repeat (8) @(posedge clk);
    chk("pullup_on", pullup_on, 8'h00);
    xfer(0, 4'h8, 8'h00);
    summarize();
  end
endmodule // tb
